// file: rtl/pim_irq_pm.sv
`timescale 1ns/10ps

// What this block does
// - UART status bits read as inverse of the source word not-pending bits.
// - Each pin status bit returns raw or inverted level per sense config.
// - UART mask bits set at reset; serial EEPROM may replace them.
// - Subsystem-id mode suppresses every pin interrupt regardless of masks.
// - Pin mask bits set at reset; serial EEPROM may replace them.
// - Sixteen sources; parallel port shares bit 4, power-down shares bit 5.
// - Interrupt pin field: 0 none, 1 INTA, 2 INTB; defaults 1 and 2.
// - Interrupt pin field read-only to config writes, loaded by EEPROM only.
// - Interrupt pins are level, held low while an enabled source is active.
// - Global status word readable by both functions.
// - UART interrupts only when pending and its mask bit 19:16 set.
// - Parallel port interrupt mode takes over the pin 0 slot.
// - Per-function wake state; PME released only when both statuses clear.
// - Idle means no UART pending and all transmitters and receivers idle.
// - Power-down request only if still idle after selected filter time.
// - Device never changes its own power state.
// - Nonzero filter makes bit 5 sticky, clear on read, masked by bit 21.
// - In D3 UART clocks stop; only ring trailing edge wakes.
// - In D2 modem or serial-input changes wake; serial wake restarts clock.
// - D2/D3 stops clocks, blocks interrupt, refuses I/O and memory decodes.
// - Wake drives PME at once, bypassing filter, when enable bit 8 set.
// - Wake mask bits cleared after reset so all lines may wake.
// - Wake sets sticky status bit 15, write-one-clear; drives PME when enabled.
// - Zero filter makes bit 5 report pin 1 and disables power-down interrupt.
// - Filter codes 01, 10, 11 select 4, 129 and 518 seconds.
module pim_irq_pm #(
	parameter logic [32:0] FILT1_CYC = pim_pkg::FILT1_CYC,
	parameter logic [32:0] FILT2_CYC = pim_pkg::FILT2_CYC,
	parameter logic [32:0] FILT3_CYC = pim_pkg::FILT3_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire pim_pkg::pim_acc_t acc,
	output logic [31:0]            reg_rdata,
	input  wire pim_pkg::pim_ee_t  ee,
	input  wire pim_pkg::pim_uart_t uart,
	input  wire logic [11:0]       multi_purpose_pin,
	input  wire logic [1:0]        dev_mode,
	input  wire logic              par_irq,
	input  wire logic              f1_low_power,
	input  wire logic              f1_pme_active,
	output logic [3:0]             uart_clk_en,
	output logic                   io_decode_en,
	output pim_pkg::pim_pins_t     pins
);

	// ****************************************
	// State
	// ****************************************
	pim_pkg::pim_state_t s_reg;
	pim_pkg::pim_state_t s_next;

	logic [3:0]  pend;
	logic [11:0] pin_lvl;
	logic [31:0] gstat;
	logic        low_pw;
	logic        idle_all;
	logic [1:0]  filt;
	logic [32:0] filt_cyc;
	logic        pd_req;
	logic [3:0]  ring_fall;
	logic [15:0] ml_chg;
	logic [3:0]  sdi_chg;
	logic [3:0]  sdi_wk;
	logic        wake;
	logic        f0_irq;
	logic        f1_irq;
	logic        pin0_src;
	logic        gstat_rd;
	logic        pm_wr;

	always_comb
	begin
		pend = ~{uart.src_word[pim_pkg::USRC_CH3], uart.src_word[pim_pkg::USRC_CH2],
			uart.src_word[pim_pkg::USRC_CH1], uart.src_word[pim_pkg::USRC_CH0]};
		pin_lvl = s_reg.pin_s2 ^ s_reg.sense;
		filt = s_reg.lctl[pim_pkg::LCTL_FILT_LO +: 2];
		low_pw = (s_reg.pm_state == pim_pkg::PM_D2) || (s_reg.pm_state == pim_pkg::PM_D3);
		idle_all = (pend == 4'h0) && (&uart.idle);
		gstat = {s_reg.irq_mask, pin_lvl[11:2],
			(filt == pim_pkg::FILT_OFF) ? pin_lvl[1] : s_reg.pd_sticky,
			(dev_mode == pim_pkg::MODE_PAR) ? par_irq : pin_lvl[0], pend};
		unique case (filt)
			2'h1:    filt_cyc = FILT1_CYC;
			2'h2:    filt_cyc = FILT2_CYC;
			2'h3:    filt_cyc = FILT3_CYC;
			default: filt_cyc = 33'h0_0000_0001;
		endcase
		// A filter switched off or a sleep entered mid-count must not fire a request
		pd_req = (s_reg.pd == pim_pkg::PD_COUNT) && idle_all && !low_pw
			&& (filt != pim_pkg::FILT_OFF)
			&& (s_reg.pd_cnt >= filt_cyc - 33'h0_0000_0001);
		for (int c = 0; c < 4; c++)
		begin
			ring_fall[c] = s_reg.ml_prev[4 * c + 3] && !s_reg.ml_s2[4 * c + 3];
		end
		ml_chg = (s_reg.ml_prev ^ s_reg.ml_s2);
		sdi_chg = (s_reg.sdi_prev ^ s_reg.sdi_s2);
		wake = 1'b0;
		sdi_wk = 4'h0;
		for (int c = 0; c < 4; c++)
		begin
			if (s_reg.pm_state == pim_pkg::PM_D3)
				wake = wake | (ring_fall[c] && !uart.wake_mask[5 * c + 3]);
			else if (s_reg.pm_state == pim_pkg::PM_D2)
			begin
				sdi_wk[c] = sdi_chg[c] && !uart.wake_mask[5 * c + 4];
				wake = wake | sdi_wk[c] | (|(ml_chg[4 * c +: 4] & ~uart.wake_mask[5 * c +: 4]));
			end
		end
		// Power-down interrupt belongs to the UART function
		f0_irq = !low_pw && ((|(pend & s_reg.irq_mask[3:0]))
			|| ((filt != pim_pkg::FILT_OFF) && s_reg.pd_sticky && s_reg.irq_mask[pim_pkg::M21]));
		pin0_src = (dev_mode == pim_pkg::MODE_PAR) ? par_irq : pin_lvl[0];
		f1_irq = !f1_low_power && (((dev_mode == pim_pkg::MODE_PAR) && par_irq
			&& s_reg.irq_mask[pim_pkg::M20]) || ((dev_mode != pim_pkg::MODE_SSID)
			&& ((|(pin_lvl[11:2] & s_reg.irq_mask[15:6]))
			|| (pin0_src && s_reg.irq_mask[pim_pkg::M20])
			|| ((filt == pim_pkg::FILT_OFF) && pin_lvl[1] && s_reg.irq_mask[pim_pkg::M21]))));
		gstat_rd = acc.rd && !acc.cfg && !low_pw && (acc.addr == pim_pkg::GSTAT_OFF);
		pm_wr = acc.wr && acc.cfg && (acc.addr == pim_pkg::PMCS_OFF);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		s_next = s_reg;
		s_next.pin_s1 = multi_purpose_pin;
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.ml_s1 = uart.modem_line;
		s_next.ml_s2 = s_reg.ml_s1;
		s_next.ml_prev = s_reg.ml_s2;
		s_next.sdi_s1 = uart.serial_input;
		s_next.sdi_s2 = s_reg.sdi_s1;
		s_next.sdi_prev = s_reg.sdi_s2;
		s_next.rdata = 32'h0000_0000;
		if (acc.rd && acc.cfg)
		begin
			if (acc.addr == pim_pkg::PMCS_OFF)
				s_next.rdata = {16'h0000, s_reg.pme_sts, 6'h00, s_reg.pme_en, 6'h00, s_reg.pm_state};
			else if (acc.addr == pim_pkg::INTPIN_OFF)
				s_next.rdata = {16'h0000, s_reg.f0_pin, 8'h00};
		end
		else if (acc.rd && !low_pw) // Decodes refused while asleep
		begin
			if (acc.addr == pim_pkg::GSTAT_OFF)
				s_next.rdata = gstat;
			else if (acc.addr == pim_pkg::LCTL_OFF)
				s_next.rdata = s_reg.lctl;
			else if (acc.addr == pim_pkg::SENSE_OFF)
				s_next.rdata = {20'h00000, s_reg.sense};
		end
		if (acc.wr && !acc.cfg && !low_pw)
		begin
			if (acc.addr == pim_pkg::GSTAT_OFF)
				s_next.irq_mask = acc.wdata[31:16];
			else if (acc.addr == pim_pkg::LCTL_OFF)
				s_next.lctl = acc.wdata;
			else if (acc.addr == pim_pkg::SENSE_OFF)
				s_next.sense = acc.wdata[11:0];
		end
		// Only driver writes move the power state; D1 is not offered
		if (pm_wr)
		begin
			if (acc.wdata[1:0] != 2'h1)
				s_next.pm_state = acc.wdata[1:0];
			s_next.pme_en = acc.wdata[pim_pkg::PM_EN_BIT];
			if (acc.wdata[pim_pkg::PM_STS_BIT])
				s_next.pme_sts = 1'b0;
		end
		if (wake) // Set beats a same-cycle clear
			s_next.pme_sts = 1'b1;
		if (ee.load) // Interrupt pin has no config write path
		begin
			s_next.irq_mask = ee.irq_mask;
			s_next.f0_pin = ee.f0_pin;
			s_next.f1_pin = ee.f1_pin;
		end
		if (s_reg.pm_state != pim_pkg::PM_D2)
			s_next.sdi_wake = 4'h0;
		else
			s_next.sdi_wake = s_reg.sdi_wake | sdi_wk;
		// Filter restarts on any activity so intermittent traffic stays quiet
		unique case (s_reg.pd)
			pim_pkg::PD_IDLE:
			begin
				s_next.pd_cnt = 33'h0_0000_0000;
				if (idle_all && (filt != pim_pkg::FILT_OFF) && !low_pw)
					s_next.pd = pim_pkg::PD_COUNT;
			end
			pim_pkg::PD_COUNT:
			begin
				s_next.pd_cnt = s_reg.pd_cnt + 33'h0_0000_0001;
				if (!idle_all || (filt == pim_pkg::FILT_OFF) || low_pw)
					s_next.pd = pim_pkg::PD_IDLE;
				else if (pd_req)
					s_next.pd = pim_pkg::PD_DONE;
			end
			pim_pkg::PD_DONE:
			begin
				if (!idle_all || (filt == pim_pkg::FILT_OFF))
					s_next.pd = pim_pkg::PD_IDLE;
			end
			default: s_next.pd = pim_pkg::PD_IDLE;
		endcase
		if (gstat_rd)
			s_next.pd_sticky = 1'b0;
		if (pd_req)
			s_next.pd_sticky = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg <= '0;
			s_reg.lctl <= pim_pkg::LCTL_RST;
			s_reg.sense <= pim_pkg::SENSE_RST;
			s_reg.irq_mask <= pim_pkg::IRQ_MASK_RST;
			s_reg.pm_state <= pim_pkg::PM_D0;
			s_reg.f0_pin <= pim_pkg::F0_PIN_RST;
			s_reg.f1_pin <= pim_pkg::F1_PIN_RST;
			s_reg.pd <= pim_pkg::PD_IDLE;
		end
		else
			s_reg <= s_next;
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb
	begin
		reg_rdata = s_reg.rdata;
		io_decode_en = !low_pw;
		for (int c = 0; c < 4; c++)
		begin
			// Stale serial wake flags must not leak into a direct D2 to D3 move
			uart_clk_en[c] = (s_reg.pm_state == pim_pkg::PM_D0)
				|| ((s_reg.pm_state == pim_pkg::PM_D2) && s_reg.sdi_wake[c]);
		end
		pins.inta_o = 1'b0;
		pins.intb_o = 1'b0;
		pins.pme_o = 1'b0;
		pins.inta_oe_n = !((f0_irq && (s_reg.f0_pin == pim_pkg::PIN_INTA))
			|| (f1_irq && (s_reg.f1_pin == pim_pkg::PIN_INTA)));
		pins.intb_oe_n = !((f0_irq && (s_reg.f0_pin == pim_pkg::PIN_INTB))
			|| (f1_irq && (s_reg.f1_pin == pim_pkg::PIN_INTB)));
		pins.pme_oe_n = !((s_reg.pme_sts && s_reg.pme_en) || f1_pme_active);
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_wake_seen;
		wake ##1 s_reg.pme_sts;
	endsequence

	property p_stat_uart;
		@(posedge mclk) disable iff (!rst_b)
		(acc.rd && !acc.cfg && !low_pw && acc.addr == pim_pkg::GSTAT_OFF)
		|=> reg_rdata[3:0] == $past(pend);
	endproperty
	a_stat_uart: assert property (p_stat_uart) else $error("uart status bits wrong");

	property p_ssid_quiet;
		@(posedge mclk) disable iff (!rst_b)
		(dev_mode == pim_pkg::MODE_SSID) |-> !f1_irq;
	endproperty
	a_ssid_quiet: assert property (p_ssid_quiet) else $error("pin interrupt in ssid mode");

	property p_sleep_block;
		@(posedge mclk) disable iff (!rst_b)
		low_pw |-> (!f0_irq && !io_decode_en);
	endproperty
	a_sleep_block: assert property (p_sleep_block) else $error("sleep not blocking");

	property p_d3_clock;
		@(posedge mclk) disable iff (!rst_b)
		(s_reg.pm_state == pim_pkg::PM_D3) |-> (uart_clk_en == 4'h0);
	endproperty
	a_d3_clock: assert property (p_d3_clock) else $error("uart clock runs in D3");

	property p_wake_pme;
		@(posedge mclk) disable iff (!rst_b)
		(wake && s_reg.pme_en && !pm_wr) |=> !pins.pme_oe_n;
	endproperty
	a_wake_pme: assert property (p_wake_pme) else $error("wake did not drive pme");

	property p_wake_sticky;
		@(posedge mclk) disable iff (!rst_b)
		wake |-> s_wake_seen;
	endproperty
	a_wake_sticky: assert property (p_wake_sticky) else $error("wake status not set");

	property p_pd_sticky;
		@(posedge mclk) disable iff (!rst_b)
		pd_req |=> s_reg.pd_sticky ##1 (s_reg.pd != pim_pkg::PD_COUNT);
	endproperty
	a_pd_sticky: assert property (p_pd_sticky) else $error("power-down not latched");

	property p_pin_ro;
		@(posedge mclk) disable iff (!rst_b)
		!ee.load |=> (s_reg.f0_pin == $past(s_reg.f0_pin)) && (s_reg.f1_pin == $past(s_reg.f1_pin));
	endproperty
	a_pin_ro: assert property (p_pin_ro) else $error("interrupt pin field changed");

	property p_own_state;
		@(posedge mclk) disable iff (!rst_b)
		!pm_wr |=> $stable(s_reg.pm_state);
	endproperty
	a_own_state: assert property (p_own_state) else $error("power state moved alone");

	property p_pd_idle;
		@(posedge mclk) disable iff (!rst_b)
		pd_req |-> idle_all && (filt != pim_pkg::FILT_OFF);
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("power-down request while busy");

endmodule : pim_irq_pm

// file: include/pim_pkg.sv
package pim_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_HZ     = 10_000_000;
	localparam int          FILT1_S    = 4;
	localparam int          FILT2_S    = 129;
	localparam int          FILT3_S    = 518;
	localparam logic [32:0] FILT1_CYC  = 33'(64'(FILT1_S) * 64'(CLK_HZ));
	localparam logic [32:0] FILT2_CYC  = 33'(64'(FILT2_S) * 64'(CLK_HZ));
	localparam logic [32:0] FILT3_CYC  = 33'(64'(FILT3_S) * 64'(CLK_HZ));

	// ****************************************
	// Offsets and fields
	// ****************************************
	localparam logic [7:0]  LCTL_OFF     = 8'h00;
	localparam logic [7:0]  SENSE_OFF    = 8'h04;
	localparam logic [7:0]  GSTAT_OFF    = 8'h1C;
	localparam logic [7:0]  INTPIN_OFF   = 8'h3C;
	localparam logic [7:0]  PMCS_OFF     = 8'h44;
	localparam int          LCTL_FILT_LO = 5;
	localparam int          PM_EN_BIT   = 8;
	localparam int          PM_STS_BIT  = 15;
	localparam int          INTPIN_LO   = 8;
	localparam int          M20         = 4;
	localparam int          M21         = 5;
	localparam int          USRC_CH0    = 0;
	localparam int          USRC_CH1    = 6;
	localparam int          USRC_CH2    = 18;
	localparam int          USRC_CH3    = 24;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [15:0] IRQ_MASK_RST = 16'hFFFF;
	localparam logic [31:0] LCTL_RST     = 32'h0000_0000;
	localparam logic [11:0] SENSE_RST    = 12'h000;
	localparam logic [7:0]  F0_PIN_RST   = 8'h01;
	localparam logic [7:0]  F1_PIN_RST   = 8'h02;
	localparam logic [7:0]  PIN_INTA     = 8'h01;
	localparam logic [7:0]  PIN_INTB     = 8'h02;
	localparam logic [1:0]  PM_D0        = 2'h0;
	localparam logic [1:0]  PM_D2        = 2'h2;
	localparam logic [1:0]  PM_D3        = 2'h3;
	localparam logic [1:0]  MODE_PAR     = 2'h1;
	localparam logic [1:0]  MODE_SSID    = 2'h2;
	localparam logic [1:0]  FILT_OFF     = 2'h0;

	typedef enum logic [1:0] {
		PD_IDLE  = 2'b00,
		PD_COUNT = 2'b01,
		PD_DONE  = 2'b10
	} pim_pd_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        cfg;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} pim_acc_t;

	typedef struct packed {
		logic        load;
		logic [15:0] irq_mask;
		logic [7:0]  f0_pin;
		logic [7:0]  f1_pin;
	} pim_ee_t;

	typedef struct packed {
		logic [31:0] src_word;
		logic [3:0]  idle;
		logic [15:0] modem_line;
		logic [3:0]  serial_input;
		logic [19:0] wake_mask;
	} pim_uart_t;

	typedef struct packed {
		logic inta_o;
		logic inta_oe_n;
		logic intb_o;
		logic intb_oe_n;
		logic pme_o;
		logic pme_oe_n;
	} pim_pins_t;

	typedef struct packed {
		logic [31:0] lctl;
		logic [11:0] sense;
		logic [15:0] irq_mask;
		logic        pd_sticky;
		logic [1:0]  pm_state;
		logic        pme_en;
		logic        pme_sts;
		logic [7:0]  f0_pin;
		logic [7:0]  f1_pin;
		pim_pd_t     pd;
		logic [32:0] pd_cnt;
		logic [11:0] pin_s1;
		logic [11:0] pin_s2;
		logic [15:0] ml_s1;
		logic [15:0] ml_s2;
		logic [15:0] ml_prev;
		logic [3:0]  sdi_s1;
		logic [3:0]  sdi_s2;
		logic [3:0]  sdi_prev;
		logic [3:0]  sdi_wake;
		logic [31:0] rdata;
	} pim_state_t;

endpackage : pim_pkg

// file: tb/pim_host_model.sv
`timescale 1ns/10ps

// ****************************************
// Host side of the register bus
// ****************************************
module pim_host_model (
	input  wire logic              mclk,
	output pim_pkg::pim_acc_t      acc,
	input  wire logic [31:0]       reg_rdata
);
	initial acc = '0;

	// Strobe for one edge; data is only valid the cycle after
	task automatic xfer(input logic c, input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(negedge mclk);
		acc = '{rd: !w, wr: w, cfg: c, addr: a, wdata: d};
		@(negedge mclk);
		acc = '0;
		q = reg_rdata;
	endtask : xfer

	// Back to D0 and clear wake status after a wake
	task automatic wake_ack();
		logic [31:0] q;
		xfer(1'b1, 1'b1, pim_pkg::PMCS_OFF, 32'h0000_8100, q);
	endtask : wake_ack
endmodule : pim_host_model

// file: tb/pci_interrupt_and_power_mgmt_tb.sv
`timescale 1ns/10ps

module pci_interrupt_and_power_mgmt_tb;
	logic               mclk;
	logic               rst_b;
	pim_pkg::pim_acc_t  acc;
	logic [31:0]        reg_rdata;
	logic [31:0]        q;
	pim_pkg::pim_ee_t   ee;
	pim_pkg::pim_uart_t uart;
	logic [11:0]        mpp;
	logic [1:0]         dev_mode;
	logic               par_irq;
	logic               f1_low_power;
	logic               f1_pme_active;
	logic [3:0]         uart_clk_en;
	logic               io_decode_en;
	pim_pkg::pim_pins_t pins;
	int                 n_fail;
	int                 comparisons;

	pim_irq_pm #(.FILT1_CYC(33'h14), .FILT2_CYC(33'h28), .FILT3_CYC(33'h3C)) pim_irq_pm_i (
		.mclk(mclk), .rst_b(rst_b), .acc(acc), .reg_rdata(reg_rdata), .ee(ee),
		.uart(uart), .multi_purpose_pin(mpp), .dev_mode(dev_mode), .par_irq(par_irq),
		.f1_low_power(f1_low_power), .f1_pme_active(f1_pme_active),
		.uart_clk_en(uart_clk_en), .io_decode_en(io_decode_en), .pins(pins));
	pim_host_model pim_host_model_i (.mclk(mclk), .acc(acc), .reg_rdata(reg_rdata));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic rd(input logic c, input logic [7:0] a);
		pim_host_model_i.xfer(c, 1'b0, a, 32'h0, q);
	endtask : rd

	task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dq;
		pim_host_model_i.xfer(c, 1'b1, a, d, dq);
	endtask : wr

	// Bounded wait for INTA (0) or PME (1) to be pulled low
	task automatic wait_lo(input bit pme);
		int i;
		for (i = 0; i < 200 && (pme ? pins.pme_oe_n : pins.inta_oe_n) !== 1'b0; i++)
			@(negedge mclk);
		if (i == 200)
		begin
			n_fail++;
			$display("mismatch wait expected low seen timeout");
			end_sim();
		end
	endtask : wait_lo

	task automatic eeload(input logic [15:0] m, input logic [7:0] f0);
		@(negedge mclk);
		ee = '{load: 1'b1, irq_mask: m, f0_pin: f0, f1_pin: pim_pkg::PIN_INTB};
		@(negedge mclk);
		ee.load = 1'b0;
		cyc(2);
	endtask : eeload

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_rst", q, 32'hFFFF_0000);
		rd(1'b1, pim_pkg::INTPIN_OFF);
		chk("pin_rst", 32'(q[15:8]), 32'h1);
		wr(1'b1, pim_pkg::INTPIN_OFF, 32'hFFFF_FFFF);
		rd(1'b1, pim_pkg::INTPIN_OFF);
		chk("pin_ro", 32'(q[15:8]), 32'h1);
		rd(1'b1, pim_pkg::PMCS_OFF);
		chk("pm_rst", q, 32'h0);
		chk("oe_rst", 32'({pins.inta_oe_n, pins.intb_oe_n, pins.pme_oe_n}), 32'h7);
		chk("lvl_rst", 32'({pins.inta_o, pins.intb_o, pins.pme_o}), 32'h0);
		chk("clk_rst", 32'({uart_clk_en, io_decode_en}), 32'h1F);
	endtask : t_reset

	task automatic t_uart();
		uart.src_word[0] = 1'b0;
		cyc(4);
		chk("inta_u", 32'(pins.inta_oe_n), 32'h0);
		eeload(16'hFFFE, pim_pkg::PIN_INTB);
		chk("intb_m", 32'(pins.intb_oe_n), 32'h1);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_u", q, 32'hFFFE_0001);
		wr(1'b0, pim_pkg::GSTAT_OFF, 32'hFFFF_0000);
		cyc(1);
		chk("intb_u", 32'({pins.inta_oe_n, pins.intb_oe_n}), 32'h2);
		eeload(16'hFFFF, 8'h00);
		chk("pin_none", 32'({pins.inta_oe_n, pins.intb_oe_n}), 32'h3);
		eeload(16'hFFFF, pim_pkg::PIN_INTA);
		chk("inta_d", 32'(pins.inta_oe_n), 32'h0);
		uart.src_word[0] = 1'b1;
	endtask : t_uart

	task automatic t_pins();
		mpp[3] = 1'b1;
		cyc(4);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_p", q, 32'hFFFF_0080);
		chk("intb_p", 32'(pins.intb_oe_n), 32'h0);
		f1_low_power = 1'b1;
		cyc(1);
		chk("intb_lp", 32'(pins.intb_oe_n), 32'h1);
		f1_low_power = 1'b0;
		wr(1'b0, pim_pkg::SENSE_OFF, 32'h8);
		cyc(4);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_inv", q, 32'hFFFF_0000);
		wr(1'b0, pim_pkg::SENSE_OFF, 32'h0);
		dev_mode = pim_pkg::MODE_SSID;
		cyc(4);
		chk("intb_ss", 32'(pins.intb_oe_n), 32'h1);
		mpp = 12'h001;
		dev_mode = pim_pkg::MODE_PAR;
		cyc(4);
		chk("intb_pp", 32'(pins.intb_oe_n), 32'h1);
		par_irq = 1'b1;
		cyc(4);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_pp", q, 32'hFFFF_0010);
		chk("intb_pi", 32'(pins.intb_oe_n), 32'h0);
		par_irq = 1'b0;
		dev_mode = 2'h0;
		mpp = 12'h0;
		cyc(4);
	endtask : t_pins

	task automatic t_pdown();
		uart.idle = 4'hF;
		wr(1'b0, pim_pkg::LCTL_OFF, 32'h20);
		wait_lo(1'b0);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_pd", q, 32'hFFFF_0020);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_clr", q, 32'hFFFF_0000);
		chk("inta_pd", 32'(pins.inta_oe_n), 32'h1);
		rd(1'b1, pim_pkg::PMCS_OFF);
		chk("pm_keep", q, 32'h0);
		uart.idle = 4'h0;
		wr(1'b0, pim_pkg::LCTL_OFF, 32'h0);
	endtask : t_pdown

	// Longer filter codes: no request before the selected count, one after it
	task automatic t_filt(input logic [1:0] code, input int n);
		uart.idle = 4'hF;
		wr(1'b0, pim_pkg::LCTL_OFF, 32'(code) << pim_pkg::LCTL_FILT_LO);
		cyc(n - 2);
		chk("pd_early", 32'(pins.inta_oe_n), 32'h1);
		wait_lo(1'b0);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_pdn", q, 32'hFFFF_0020);
		uart.idle = 4'h0;
		wr(1'b0, pim_pkg::LCTL_OFF, 32'h0);
	endtask : t_filt

	task automatic t_d3();
		wr(1'b1, pim_pkg::PMCS_OFF, 32'h0000_0103);
		cyc(1);
		chk("clk_d3", 32'({uart_clk_en, io_decode_en}), 32'h0);
		uart.src_word[0] = 1'b0;
		uart.modem_line[3] = 1'b1;
		cyc(6);
		chk("no_wake", 32'({pins.inta_oe_n, pins.pme_oe_n}), 32'h3);
		rd(1'b0, pim_pkg::GSTAT_OFF);
		chk("stat_d3", q, 32'h0);
		uart.modem_line[3] = 1'b0;
		wait_lo(1'b1);
		rd(1'b1, pim_pkg::PMCS_OFF);
		chk("pm_sts", q, 32'h0000_8103);
		f1_pme_active = 1'b1;
		pim_host_model_i.wake_ack();
		chk("pme_f1", 32'(pins.pme_oe_n), 32'h0);
		f1_pme_active = 1'b0;
		cyc(1);
		chk("pme_rel", 32'({pins.pme_oe_n, io_decode_en}), 32'h3);
		uart.src_word[0] = 1'b1;
	endtask : t_d3

	task automatic t_d2();
		wr(1'b1, pim_pkg::PMCS_OFF, 32'h0000_0102);
		uart.serial_input[1] = 1'b1;
		wait_lo(1'b1);
		chk("clk_d2", 32'(uart_clk_en), 32'h2);
		pim_host_model_i.wake_ack();
		cyc(1);
		chk("clk_d0", 32'({uart_clk_en, pins.pme_oe_n}), 32'h1F);
		uart.serial_input[1] = 1'b0;
	endtask : t_d2

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial
	begin
		n_fail = 0;
		comparisons = 0;
		rst_b = 1'b0;
		ee = '0;
		uart = '{src_word: 32'h0104_0041, default: '0};
		mpp = 12'h0;
		dev_mode = 2'h0;
		par_irq = 1'b0;
		f1_low_power = 1'b0;
		f1_pme_active = 1'b0;
		cyc(16);
		rst_b = 1'b1;
		t_reset();
		t_uart();
		t_pins();
		t_pdown();
		t_filt(2'h2, 40);
		t_filt(2'h3, 60);
		t_d3();
		t_d2();
		end_sim();
	end
endmodule : pci_interrupt_and_power_mgmt_tb
